// ===== hw/ppp_pkg.sv
`default_nettype none

package ppp_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [1:0] OFF_DATA = 2'h0;
  localparam logic [1:0] OFF_STATUS = 2'h1;
  localparam logic [1:0] OFF_CONTROL = 2'h2;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;

  // ------------------------------------------------------------
  // field positions and constant bits
  // ------------------------------------------------------------
  localparam int CT_DIR_BIT = 5;
  localparam int CT_IRQEN_BIT = 4;
  localparam int CT_SEL_BIT = 3;
  localparam int CT_INIT_BIT = 2;
  localparam int CT_AUTOFD_BIT = 1;
  localparam int CT_STROBE_BIT = 0;
  localparam int CT_W = 6;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [2:0] CTRL_RB_UNUSED = 3'h0;
  localparam logic [2:0] STAT_UNUSED = 3'h0;

  // ------------------------------------------------------------
  // timing, in ns and in 100 ns clock cycles
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int STROBE_MIN_NS = 500;
  localparam int SETUP_MIN_NS = 500;
  localparam int HOLD_MIN_NS = 500;
  localparam int INIT_MIN_NS = 50000;
  localparam int STROBE_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYC = (INIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;
  localparam int FIFO_DEPTH = 32;
  localparam int DATA_W = 8;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } ppp_bus_req_type;

  typedef struct packed {
    logic busy;
    logic ack_n;
    logic paper_end;
    logic selected;
    logic error_n;
  } ppp_stat_pins_type;

  typedef struct packed {
    logic strobe_n;
    logic autofd_n;
    logic init_n;
    logic select_in_n;
  } ppp_ctl_pins_type;

  typedef enum logic [1:0] {
    STB_IDLE = 2'h0,
    STB_SETUP = 2'h1,
    STB_PULSE = 2'h3,
    STB_HOLD = 2'h2
  } ppp_stb_state_type;

endpackage

`default_nettype wire

// ===== hw/ppp_fifo.sv
`default_nettype none

module ppp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] count;
    logic ready;
  } ppp_fifo_state_type;

  ppp_fifo_state_type s_r;
  ppp_fifo_state_type s_nxt;
  logic push;
  logic pop;

  // wrap explicitly so depths that are not powers of two work too
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign push = in_valid_in && s_r.ready;
  assign pop = out_ready_in && (s_r.count != '0);

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data_in;
      s_nxt.wp = next_ptr(s_r.wp);
    end
    if (pop)
    begin
      s_nxt.rp = next_ptr(s_r.rp);
    end
    if (push && !pop)
    begin
      s_nxt.count = s_r.count + 1'b1;
    end
    else if (pop && !push)
    begin
      s_nxt.count = s_r.count - 1'b1;
    end
    // ready is held in a flop so the producer sees no combinational path
    s_nxt.ready = (s_nxt.count != CW'(DEPTH));
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s_r <= '0;
      s_r.ready <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign in_ready_out = s_r.ready;
  assign out_valid_out = (s_r.count != '0);
  assign out_data_out = s_r.mem[s_r.rp];

endmodule

`default_nettype wire

// ===== hw/ppp_port.sv
`default_nettype none

module ppp_port #(
  parameter int DEPTH = ppp_pkg::FIFO_DEPTH,
  parameter int SETUP_CYC = ppp_pkg::SETUP_CYC,
  parameter int STROBE_CYC = ppp_pkg::STROBE_CYC,
  parameter int HOLD_CYC = ppp_pkg::HOLD_CYC,
  parameter int INIT_CYC = ppp_pkg::INIT_CYC
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire ppp_pkg::ppp_bus_req_type bus_in,
  output logic [7:0] rdata_out,
  output logic wr_ready_out,
  input wire ppp_pkg::ppp_stat_pins_type stat_pins_in,
  output ppp_pkg::ppp_ctl_pins_type ctl_pins_out,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic irq_out
);

  localparam int CW = ppp_pkg::CNT_W;

  typedef struct packed {
    ppp_pkg::ppp_stat_pins_type stat_meta;
    ppp_pkg::ppp_stat_pins_type stat_sync;
    logic ack_prev;
    logic [7:0] data_meta;
    logic [7:0] data_sync;
    logic [ppp_pkg::CT_W-1:0] ctrl;
    logic [7:0] latch;
    logic loaded;
    ppp_pkg::ppp_stb_state_type st;
    logic [CW-1:0] cnt;
    logic [CW-1:0] stab;
    logic [CW-1:0] init_cnt;
    ppp_pkg::ppp_ctl_pins_type pins;
    logic data_oe;
    logic irq;
    logic [7:0] rdata;
  } ppp_port_state_type;

  ppp_port_state_type s_r;
  ppp_port_state_type s_nxt;
  logic fifo_push;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_ready;
  logic [7:0] fifo_data;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // counters stick at all ones rather than wrap back to zero
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    sat_inc = (v == '1) ? v : v + 1'b1;
  endfunction

  function automatic logic reached(input logic [CW-1:0] v, input int cyc);
    reached = (v >= CW'(cyc - 1));
  endfunction

  function automatic logic [7:0] read_value(
    input logic [1:0] addr,
    input ppp_port_state_type s
  );
    case (addr)
      ppp_pkg::OFF_DATA:
        read_value = s.ctrl[ppp_pkg::CT_DIR_BIT] ? s.data_sync : s.latch;
      ppp_pkg::OFF_STATUS:
        read_value = {s.stat_sync.busy,
                      s.stat_sync.ack_n,
                      s.stat_sync.paper_end,
                      s.stat_sync.selected,
                      s.stat_sync.error_n,
                      ppp_pkg::STAT_UNUSED};
      ppp_pkg::OFF_CONTROL:
        // direction bit is hidden behind the constant upper bits
        read_value = {ppp_pkg::CTRL_RB_UNUSED, s.ctrl[4:0]};
      default:
        read_value = ppp_pkg::UNMAPPED_VAL;
    endcase
  endfunction

  // ------------------------------------------------------------
  // data buffer
  // ------------------------------------------------------------
  // writes at offset zero queue here; a full buffer drops the write
  assign fifo_push = bus_in.wr && (bus_in.addr == ppp_pkg::OFF_DATA);
  assign fifo_pop = (s_r.st == ppp_pkg::STB_IDLE) && fifo_valid
                    && !s_r.ctrl[ppp_pkg::CT_STROBE_BIT] && !s_r.loaded;

  ppp_fifo #(
    .WIDTH(ppp_pkg::DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_ready),
    .in_data_in(bus_in.wdata),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_data)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    // pins are asynchronous: two flops before anything looks
    s_nxt.stat_meta = stat_pins_in;
    s_nxt.stat_sync = s_r.stat_meta;
    s_nxt.data_meta = data_in;
    s_nxt.data_sync = s_r.data_meta;
    s_nxt.ack_prev = s_r.stat_sync.ack_n;

    if (bus_in.wr && (bus_in.addr == ppp_pkg::OFF_CONTROL))
    begin
      s_nxt.ctrl = bus_in.wdata[ppp_pkg::CT_W-1:0];
    end
    if (bus_in.rd)
    begin
      s_nxt.rdata = read_value(bus_in.addr, s_r);
    end

    s_nxt.irq = s_r.ctrl[ppp_pkg::CT_IRQEN_BIT]
                && s_r.stat_sync.ack_n && !s_r.ack_prev;

    s_nxt.stab = sat_inc(s_r.stab);
    s_nxt.cnt = sat_inc(s_r.cnt);

    case (s_r.st)
      ppp_pkg::STB_IDLE:
      begin
        if (s_r.ctrl[ppp_pkg::CT_STROBE_BIT])
        begin
          s_nxt.st = ppp_pkg::STB_SETUP;
        end
        // the latch keeps its byte until a strobe has taken it, so no queued byte is skipped
        else if (fifo_valid && !s_r.loaded)
        begin
          s_nxt.latch = fifo_data;
          s_nxt.loaded = 1'b1;
          s_nxt.stab = '0;
        end
      end
      ppp_pkg::STB_SETUP:
      begin
        // a strobe request withdrawn before it fires is simply dropped
        if (!s_r.ctrl[ppp_pkg::CT_STROBE_BIT])
        begin
          s_nxt.st = ppp_pkg::STB_IDLE;
        end
        else if (reached(s_r.stab, SETUP_CYC) && !s_r.stat_sync.busy)
        begin
          s_nxt.pins.strobe_n = 1'b0;
          s_nxt.cnt = '0;
          s_nxt.st = ppp_pkg::STB_PULSE;
        end
      end
      ppp_pkg::STB_PULSE:
      begin
        // stretched to the least width even if software clears early
        if (reached(s_r.cnt, STROBE_CYC) && !s_r.ctrl[ppp_pkg::CT_STROBE_BIT])
        begin
          s_nxt.pins.strobe_n = 1'b1;
          s_nxt.cnt = '0;
          s_nxt.st = ppp_pkg::STB_HOLD;
        end
      end
      ppp_pkg::STB_HOLD:
      begin
        if (reached(s_r.cnt, HOLD_CYC))
        begin
          s_nxt.st = ppp_pkg::STB_IDLE;
          s_nxt.loaded = 1'b0;
        end
      end
      default:
      begin
        s_nxt.st = ppp_pkg::STB_IDLE;
        s_nxt.pins.strobe_n = 1'b1;
      end
    endcase

    // initialize: active while the bit is zero, then held out to the least width
    if (!s_r.ctrl[ppp_pkg::CT_INIT_BIT])
    begin
      s_nxt.init_cnt = '0;
      s_nxt.pins.init_n = 1'b0;
    end
    else
    begin
      s_nxt.init_cnt = sat_inc(s_r.init_cnt);
      s_nxt.pins.init_n = reached(s_r.init_cnt, INIT_CYC);
    end

    s_nxt.pins.select_in_n = !s_r.ctrl[ppp_pkg::CT_SEL_BIT];
    s_nxt.pins.autofd_n = !s_r.ctrl[ppp_pkg::CT_AUTOFD_BIT];
    s_nxt.data_oe = !s_r.ctrl[ppp_pkg::CT_DIR_BIT];
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s_r <= '0;
      s_r.ctrl <= ppp_pkg::CTRL_RESET;
      s_r.st <= ppp_pkg::STB_IDLE;
      s_r.pins.strobe_n <= 1'b1;
      s_r.pins.autofd_n <= 1'b1;
      s_r.pins.init_n <= 1'b0;
      s_r.pins.select_in_n <= 1'b1;
      s_r.data_oe <= 1'b1;
      // idle acknowledge level, so no false rising edge follows reset
      s_r.stat_meta.ack_n <= 1'b1;
      s_r.stat_sync.ack_n <= 1'b1;
      s_r.ack_prev <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rdata_out = s_r.rdata;
  assign wr_ready_out = fifo_ready;
  assign ctl_pins_out = s_r.pins;
  assign data_out = s_r.latch;
  assign data_oe_out = s_r.data_oe;
  assign irq_out = s_r.irq;

endmodule

`default_nettype wire

// ===== testbench/ppp_port_asserts.sv
`default_nettype none

module ppp_port_asserts #(
  parameter int STROBE_CYC = 5,
  parameter int HOLD_CYC = 5,
  parameter int INIT_CYC = 500
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire ppp_pkg::ppp_bus_req_type bus_in,
  input wire logic [7:0] rdata_out,
  input wire ppp_pkg::ppp_stat_pins_type stat_pins_in,
  input wire ppp_pkg::ppp_ctl_pins_type ctl_pins_out,
  input wire logic [7:0] data_out,
  input wire logic data_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] lo_r;
  logic [9:0] hi_r;
  logic [9:0] ini_r;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  // ----
  // run lengths, saturating so long idles never wrap
  // ----
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      lo_r <= 10'h000;
      hi_r <= 10'h3ff;
      ini_r <= 10'h000;
    end
    else
    begin
      lo_r <= ctl_pins_out.strobe_n ? 10'h000 : lo_r + 10'(lo_r != 10'h3ff);
      hi_r <= !ctl_pins_out.strobe_n ? 10'h000 : hi_r + 10'(hi_r != 10'h3ff);
      ini_r <= ctl_pins_out.init_n ? 10'h000 : ini_r + 10'(ini_r != 10'h3ff);
    end
  end

  // ----
  // properties
  // ----
  sequence ctl_wr;
    bus_in.wr && bus_in.addr == 2'h2 ##1 !(bus_in.wr && bus_in.addr == 2'h2);
  endsequence
  // pins must sit still past the synchronizer before the byte is exact
  sequence stat_rd;
    $stable(stat_pins_in) [*4] ##0 bus_in.rd && bus_in.addr == 2'h1;
  endsequence
  chk_stat_byte:
    assert property (stat_rd |=> rdata_out == {$past(stat_pins_in), 3'h0})
    else $error("status byte wrong");
  chk_ctrl_rb:
    assert property (bus_in.rd && bus_in.addr == 2'h2 |=> rdata_out[7:5] == 3'h0)
    else $error("control readback upper bits set");
  chk_unmapped_zero:
    assert property (bus_in.rd && bus_in.addr == 2'h3 |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  chk_dir_oe:
    assert property (ctl_wr |=> data_oe_out == !$past(bus_in.wdata[5], 2))
    else $error("data enable wrong");
  chk_select_out:
    assert property (ctl_wr |=> ctl_pins_out.select_in_n == !$past(bus_in.wdata[3], 2))
    else $error("select output wrong");
  chk_autofd_out:
    assert property (ctl_wr |=> ctl_pins_out.autofd_n == !$past(bus_in.wdata[1], 2))
    else $error("line feed output wrong");
  chk_strobe_width:
    assert property ($rose(ctl_pins_out.strobe_n) |-> lo_r >= STROBE_CYC)
    else $error("strobe too short");
  chk_data_hold:
    assert property ($changed(data_out) |-> ctl_pins_out.strobe_n && hi_r >= HOLD_CYC)
    else $error("data moved near strobe");
  chk_init_width:
    assert property ($rose(ctl_pins_out.init_n) |-> ini_r >= INIT_CYC)
    else $error("init pulse too short");
endmodule

bind ppp_port ppp_port_asserts #(.STROBE_CYC(STROBE_CYC), .HOLD_CYC(HOLD_CYC),
  .INIT_CYC(INIT_CYC)) u_chk (.clk_in, .nrst_in, .bus_in, .rdata_out, .stat_pins_in,
  .ctl_pins_out, .data_out, .data_oe_out);

`default_nettype wire

// ===== testbench/ppp_printer_model.sv
`default_nettype none

module ppp_printer #(
  parameter int ACK_CYC = 50,
  parameter logic [7:0] EXT_DATA = 8'h3c
) (
  input wire logic clk_in,
  input wire ppp_pkg::ppp_ctl_pins_type ctl_pins_in,
  input wire logic [7:0] data_in,
  input wire logic stall_in,
  input wire logic [2:0] flags_in,
  output ppp_pkg::ppp_stat_pins_type stat_out,
  output logic [7:0] ext_out,
  output logic [7:0] last_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_r = 1'b0;
  logic ack_n_r = 1'b1;

  // ----
  // printer
  // ----
  // busy also follows a stall ordered by the bench
  assign stat_out = {busy_r | stall_in, ack_n_r, flags_in};
  assign ext_out = EXT_DATA;
  // one byte per strobe; a strobe during busy would be lost, as on a real printer
  always @(negedge ctl_pins_in.strobe_n)
  begin
    last_out = data_in;
    busy_r = 1'b1;
    repeat (8) @(negedge clk_in);
    ack_n_r = 1'b0;
    repeat (ACK_CYC) @(negedge clk_in);
    busy_r = 1'b0;
    @(negedge clk_in);
    ack_n_r = 1'b1;
  end
endmodule

`default_nettype wire

// ===== testbench/tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int INIT_CYC = 8;
  localparam logic [7:0] EXT = 8'h3c;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  ppp_pkg::ppp_bus_req_type bus = '0;
  ppp_pkg::ppp_stat_pins_type stat;
  ppp_pkg::ppp_ctl_pins_type ctl;
  logic [7:0] rdata;
  logic [7:0] dout;
  logic [7:0] pins;
  logic [7:0] ext;
  logic [7:0] last;
  logic [2:0] flags = 3'h0;
  logic stall = 1'b0;
  logic wr_ready;
  logic oe;
  logic irq;
  int bad_count = 0;
  int total_checks = 0;
  int irq_cnt = 0;
  int n;

  always #50 clk_in = ~clk_in;
  assign pins = oe ? dout : ext;
  always @(negedge clk_in)
    if (irq === 1'b1)
      irq_cnt++;

  ppp_port #(.INIT_CYC(INIT_CYC)) u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus),
    .rdata_out(rdata), .wr_ready_out(wr_ready), .stat_pins_in(stat), .ctl_pins_out(ctl),
    .data_in(pins), .data_out(dout), .data_oe_out(oe), .irq_out(irq));
  ppp_printer #(.EXT_DATA(EXT)) u_prn (.clk_in(clk_in), .ctl_pins_in(ctl), .data_in(pins),
    .stall_in(stall), .flags_in(flags), .stat_out(stat), .ext_out(ext), .last_out(last));

  // ----
  // tasks
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus = '{1'b1, 1'b0, a, d};
    @(negedge clk_in);
    bus = '0;
    @(negedge clk_in);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    bus = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_in);
    bus = '0;
    @(negedge clk_in);
    check(rdata, exp);
  endtask

  // leaves time after busy drops so the ack edge lands before the next enable change
  task automatic print_one(input logic [7:0] base, input logic [7:0] exp);
    int k;
    wr(2'h2, base | 8'h01);
    for (k = 0; k < 100 && ctl.strobe_n !== 1'b0; k++)
      @(negedge clk_in);
    wr(2'h2, base);
    for (k = 0; k < 200 && stat.busy !== 1'b0; k++)
      @(negedge clk_in);
    repeat (8) @(negedge clk_in);
    check(last, exp);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----
  // tests
  // ----
  initial
  begin
    repeat (10) @(negedge clk_in);
    nrst_in = 1'b1;
    for (n = 0; n < 16; n++)
    begin
      {stall, flags} = 4'(n);
      repeat (5) @(negedge clk_in);
      rd(2'h1, {n[3], 1'b1, n[2:0], 3'h0});
    end
    {stall, flags} = 4'h3;
    rd(2'h2, 8'h00);
    check({4'h0, ctl}, 8'h0d);
    wr(2'h3, 8'hff);
    rd(2'h3, 8'h00);
    wr(2'h2, 8'hee);
    rd(2'h2, 8'h0e);
    check({7'h0, oe}, 8'h00);
    check({4'h0, ctl}, 8'h08);
    rd(2'h0, EXT);
    repeat (INIT_CYC + 3) @(negedge clk_in);
    check({4'h0, ctl}, 8'h0a);
    wr(2'h2, 8'h0e);
    for (n = 0; n < 40 && wr_ready === 1'b1; n++)
      wr(2'h0, 8'h40 + 8'(n));
    check(8'(n), 8'h21);
    wr(2'h0, 8'hff);
    rd(2'h0, 8'h40);
    stall = 1'b1;
    wr(2'h2, 8'h0f);
    repeat (20) @(negedge clk_in);
    check({7'h0, ctl.strobe_n}, 8'h01);
    stall = 1'b0;
    for (n = 0; n < 33; n++)
      print_one(n == 0 ? 8'h0e : 8'h1e, 8'h40 + 8'(n));
    check(8'(irq_cnt), 8'h20);
    check({7'h0, wr_ready}, 8'h01);
    rd(2'h0, 8'h60);
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    summarize();
  end
endmodule

`default_nettype wire
